// ===== css_pkg.sv
/*
  constants shared by the converter startup sequencer: register offsets,
  field positions, reset values and timing counts.
  assumes a 50 MHz system clock and a 32-bit classic wishbone slave port.
*/
package css_pkg;
  // clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 20;
  // quiet time after a software restart, in ns, and in cycles (rounded up)
  localparam int unsigned RESTART_QUIET_NS = 1000;
  localparam int unsigned RESTART_QUIET_CYC = (RESTART_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LINK_CFG = 8'h04;
  localparam logic [7:0] OFS_CAL_CFG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  // control register bits
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned CTRL_LINK_EN_BIT = 1;
  localparam int unsigned CTRL_CAL_EN_BIT = 2;
  localparam int unsigned CTRL_TRIG_BIT = 3;
  localparam int unsigned CTRL_OVERRANGE_BIT = 4;
  // link config fields
  localparam int unsigned LCFG_MODE_LSB = 0;
  localparam int unsigned LCFG_MFLEN_LSB = 8;
  localparam int unsigned LCFG_SYNC_SEL_BIT = 16;
  // calibration config bits
  localparam int unsigned CCFG_BG_BIT = 0;
  localparam int unsigned CCFG_OFS_BIT = 1;
  // status bits
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_LINK_UP_BIT = 1;
  localparam int unsigned ST_CAL_RUN_BIT = 2;
  localparam int unsigned ST_RAIL_BIT = 3;
  localparam int unsigned ST_CAL_DONE_BIT = 4;
  // reset values
  localparam logic [4:0] CTRL_RESET = 5'h06;
  localparam logic [4:0] MODE_RESET = 5'h00;
  localparam logic [7:0] MFLEN_RESET = 8'h1f;
  // calibration run length in cycles
  localparam int unsigned CAL_RUN_CYC = 64;
  // link states
  typedef enum logic [1:0] {CSS_LINK_OFF, CSS_LINK_CGS, CSS_LINK_ILA, CSS_LINK_DATA} css_link_state_t;
endpackage

// ===== css_link_fsm.sv
/*
  link transmitter state machine: walks code-group sync, lane alignment and
  data states in answer to the receiver's sync request.
  assumes sync_n_i is active low and synchronous to clk_i.
*/
module css_link_fsm
  import css_pkg::*;
#(
  parameter int unsigned ILA_CYC = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic enable_i,
  input wire logic sync_n_i,
  // state
  output logic [1:0] state_o
);
  css_link_state_t state_q;
  logic [7:0] cnt_q;

  // link sequencing on the sync request
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable_i)
    begin
      state_q <= CSS_LINK_OFF;
      cnt_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        CSS_LINK_OFF: state_q <= CSS_LINK_CGS;
        CSS_LINK_CGS:
        begin
          cnt_q <= 8'h00;
          if (sync_n_i)
            state_q <= CSS_LINK_ILA;
        end
        CSS_LINK_ILA:
        begin
          cnt_q <= cnt_q + 8'h01;
          if (!sync_n_i)
            state_q <= CSS_LINK_CGS;
          else if (cnt_q == 8'(ILA_CYC - 1))
            state_q <= CSS_LINK_DATA;
        end
        default:
        begin
          if (!sync_n_i)
            state_q <= CSS_LINK_CGS;
        end
      endcase
    end
  end

  assign state_o = state_q;
endmodule // css_link_fsm

// ===== css_top.sv
/*
  converter startup sequencer: wishbone register file for restart, link and
  calibration enables, link and calibration options, a calibration engine and
  the low rail regulator enable.
  assumes a classic wishbone master, synchronous inputs and a 50 MHz clock.
*/
// Our own choices: the register addresses and the Wishbone slave port.
// Overview of operation
// - clearing link enable halts the link machine before link changes.
// - clearing calibration enable halts calibration before reconfiguring.
// - sync source selects single-ended pin or timestamp differential pair.
// - setting calibration enable restarts the calibration machine.
// - setting link enable restarts the link machine.
// - link transmitter sequences states on the receiver sync request.
// - a zero-to-one write of the trigger bit starts a calibration run while calibration enable is set.
module css_top
  import css_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // sync inputs
  input wire logic single_ended_sync_pin_n_i,
  input wire logic timestamp_sync_n_i,
  // supplies
  input wire logic analog_high_rail_good_i,
  output logic low_voltage_rails_en_o,
  // converter controls
  output logic soft_restart_o,
  output logic link_engine_enable_o,
  output logic [4:0] link_mode_select_o,
  output logic [7:0] multiframe_len_minus_one_o,
  output logic cal_background_o,
  output logic cal_offset_en_o,
  output logic cal_running_o,
  output logic overrange_detect_enable_o,
  output logic [1:0] link_state_o
);
  // registers and internal nets
  logic [4:0] ctrl_q;
  logic [4:0] mode_q;
  logic [7:0] mflen_q;
  logic sync_sel_q;
  logic [1:0] ccfg_q;
  logic [15:0] quiet_q;
  logic [7:0] cal_cnt_q;
  logic cal_run_q;
  logic cal_done_q;
  logic trig_prev_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic rail_en_q;
  logic sync_n_d;
  logic [1:0] link_state;
  logic wr_stb;
  logic trig_wr;

  // unmapped writes are dropped but still acknowledged
  // a write lands on the first cycle of a request
  assign wr_stb = cyc_i && stb_i && we_i && !ack_q;
  assign trig_wr = wr_stb && (adr_i == OFS_CTRL) && sel_i[0];

  // bus acknowledge, one cycle after the request is seen
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= cyc_i && stb_i && !ack_q;
  end

  // control register; restart bit self-clears after the quiet time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= CTRL_RESET;
    else if (trig_wr)
      ctrl_q <= dat_i[4:0];
    else if (ctrl_q[CTRL_RESTART_BIT] && quiet_q == 16'h0001)
      ctrl_q[CTRL_RESTART_BIT] <= 1'b0;
  end

  // restart quiet counter; writes during it are still taken
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      quiet_q <= 16'h0000;
    else if (trig_wr && dat_i[CTRL_RESTART_BIT])
      quiet_q <= 16'(RESTART_QUIET_CYC);
    else if (quiet_q != 16'h0000)
      quiet_q <= quiet_q - 16'h0001;
  end

  // link and calibration option registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= MODE_RESET;
      mflen_q <= MFLEN_RESET;
      sync_sel_q <= 1'b0;
      ccfg_q <= 2'h0;
    end
    else if (wr_stb && adr_i == OFS_LINK_CFG)
    begin
      if (sel_i[0])
        mode_q <= dat_i[LCFG_MODE_LSB +: 5];
      if (sel_i[1])
        mflen_q <= dat_i[LCFG_MFLEN_LSB +: 8];
      if (sel_i[2])
        sync_sel_q <= dat_i[LCFG_SYNC_SEL_BIT];
    end
    else if (wr_stb && adr_i == OFS_CAL_CFG && sel_i[0])
      ccfg_q <= dat_i[1:0];
  end

  // calibration engine: runs on a rising trigger while enabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      trig_prev_q <= 1'b0;
      cal_run_q <= 1'b0;
      cal_cnt_q <= 8'h00;
      cal_done_q <= 1'b0;
    end
    else
    begin
      trig_prev_q <= ctrl_q[CTRL_TRIG_BIT];
      if (!ctrl_q[CTRL_CAL_EN_BIT])
      begin
        cal_run_q <= 1'b0;
        cal_cnt_q <= 8'h00;
      end
      else if (ctrl_q[CTRL_TRIG_BIT] && !trig_prev_q && !cal_run_q)
      begin
        cal_run_q <= 1'b1;
        cal_cnt_q <= 8'(CAL_RUN_CYC - 1);
        cal_done_q <= 1'b0;
      end
      else if (cal_run_q)
      begin
        cal_cnt_q <= cal_cnt_q - 8'h01;
        if (cal_cnt_q == 8'h00)
        begin
          cal_run_q <= 1'b0;
          cal_done_q <= 1'b1;
        end
      end
    end
  end

  // sync source choice
  assign sync_n_d = sync_sel_q ? timestamp_sync_n_i : single_ended_sync_pin_n_i;

  // link transmitter state machine
  css_link_fsm u_css_link_fsm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(ctrl_q[CTRL_LINK_EN_BIT]),
    .sync_n_i(sync_n_d),
    .state_o(link_state)
  );

  // low rail enable follows high rail good one cycle later, on both the rise and the fall
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rail_en_q <= 1'b0;
    else
      rail_en_q <= analog_high_rail_good_i;
  end

  // read data mux
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= 32'h0000_0000;
    else if (adr_i == OFS_CTRL)
      dat_q <= {27'h0, ctrl_q};
    else if (adr_i == OFS_LINK_CFG)
      dat_q <= {15'h0, sync_sel_q, mflen_q, 3'h0, mode_q};
    else if (adr_i == OFS_CAL_CFG)
      dat_q <= {30'h0, ccfg_q};
    else if (adr_i == OFS_STATUS)
      dat_q <= {27'h0, cal_done_q, rail_en_q, cal_run_q, link_state == 2'h3, quiet_q != 16'h0000};
    else
      dat_q <= 32'h0000_0000; // unmapped reads as zero
  end

  // every output is a register or a plain copy of one
  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign low_voltage_rails_en_o = rail_en_q;
  assign soft_restart_o = ctrl_q[CTRL_RESTART_BIT];
  assign link_engine_enable_o = ctrl_q[CTRL_LINK_EN_BIT];
  assign overrange_detect_enable_o = ctrl_q[CTRL_OVERRANGE_BIT];
  assign link_mode_select_o = mode_q;
  assign multiframe_len_minus_one_o = mflen_q;
  assign cal_background_o = ccfg_q[CCFG_BG_BIT];
  assign cal_offset_en_o = ccfg_q[CCFG_OFS_BIT];
  assign cal_running_o = cal_run_q;
  assign link_state_o = link_state;
endmodule // css_top

// ===== css_top_assertions.sv
/* port checker for css_top
   bound to css_top; one clock, sync active-high reset */
module css_chk
  import css_pkg::*;
(
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ack_o,
  // sync and supply
  input wire logic single_ended_sync_pin_n_i,
  input wire logic timestamp_sync_n_i,
  input wire logic analog_high_rail_good_i,
  input wire logic low_voltage_rails_en_o,
  // engines
  input wire logic soft_restart_o,
  input wire logic link_engine_enable_o,
  input wire logic cal_running_o,
  input wire logic [1:0] link_state_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  int ila_q, cal_q, rst_q;
  // run lengths in cycles
  always_ff @(posedge clk_i)
  begin
    ila_q <= (link_state_o == 2'h2) ? ila_q + 1 : 0;
    cal_q <= cal_running_o ? cal_q + 1 : 0;
    rst_q <= soft_restart_o ? rst_q + 1 : 0;
  end
  sequence sync_low_s;
    link_engine_enable_o && !single_ended_sync_pin_n_i && !timestamp_sync_n_i;
  endsequence
  sequence ila_exit_s;
    $past(link_state_o) == 2'h2 && link_state_o == 2'h3;
  endsequence
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
  link_off_a: assert property (!link_engine_enable_o |=> link_state_o == 2'h0) else $error("link on");
  link_sync_a: assert property (sync_low_s ##1 link_engine_enable_o |-> link_state_o == 2'h1) else $error("no cgs");
  ila_len_a: assert property (ila_exit_s |-> ila_q == 16) else $error("ila length");
  cal_len_a: assert property ($fell(cal_running_o) |-> cal_q == CAL_RUN_CYC) else $error("cal length");
  restart_len_a: assert property ($fell(soft_restart_o) |-> rst_q == RESTART_QUIET_CYC) else $error("restart");
  rail_on_a: assert property (low_voltage_rails_en_o |-> $past(analog_high_rail_good_i)) else $error("rail on");
  rail_off_a: assert property (!analog_high_rail_good_i |=> !low_voltage_rails_en_o) else $error("rail off");
endmodule // css_chk

bind css_top css_chk u_css_chk (.clk_i, .rst_i, .ack_o, .single_ended_sync_pin_n_i, .timestamp_sync_n_i,
  .analog_high_rail_good_i, .low_voltage_rails_en_o, .soft_restart_o, .link_engine_enable_o, .cal_running_o,
  .link_state_o);

// ===== css_rx_model.sv
/* receiver and supply model: sync request pins and high rail good
   assumes bench commands change just after a rising edge */
module css_rx_model
(
  // clock and commands
  input wire logic clk_i,
  input wire logic sync_req_i,
  input wire logic use_ts_i,
  input wire logic rail_on_i,
  // pins
  output logic se_n_o,
  output logic ts_n_o,
  output logic good_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_q = 1'b0;
  logic [2:0] ramp_q = 3'h0;
  // unselected pin toggles; rail ramps before good
  always_ff @(posedge clk_i)
  begin
    idle_q <= ~idle_q;
    ramp_q <= !rail_on_i ? 3'h0 : (ramp_q == 3'h7) ? ramp_q : ramp_q + 3'h1;
  end
  assign se_n_o = use_ts_i ? idle_q : ~sync_req_i;
  assign ts_n_o = use_ts_i ? ~sync_req_i : idle_q;
  assign good_o = (ramp_q == 3'h7);
endmodule // css_rx_model

// ===== test_css_top.sv
/* self-checking bench for css_top
   assumes nothing outside; makes clock, reset and far side */
module test_css_top;
  import css_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic rd = 1'b0;
  localparam logic wr = 1'b1;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [3:0] bsel = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, rnd = 32'h50, d;
  logic ack_o, single_ended_sync_pin_n_i, timestamp_sync_n_i, analog_high_rail_good_i, low_voltage_rails_en_o;
  logic soft_restart_o, link_engine_enable_o, cal_background_o, cal_offset_en_o, cal_running_o;
  logic overrange_detect_enable_o;
  logic [4:0] link_mode_select_o;
  logic [7:0] multiframe_len_minus_one_o;
  logic [1:0] link_state_o;
  logic sync_req_i = 1'b0, use_ts_i = 1'b0, rail_on_i = 1'b0;
  logic [63:0] notes[$], note;
  int mismatches = 0, comparisons = 0;
  css_top u_css_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .single_ended_sync_pin_n_i, .timestamp_sync_n_i, .analog_high_rail_good_i, .low_voltage_rails_en_o,
    .soft_restart_o, .link_engine_enable_o, .link_mode_select_o, .multiframe_len_minus_one_o, .cal_background_o,
    .cal_offset_en_o, .cal_running_o, .overrange_detect_enable_o, .link_state_o);
  css_rx_model u_css_rx_model (.clk_i, .sync_req_i, .use_ts_i, .rail_on_i, .se_n_o(single_ended_sync_pin_n_i),
    .ts_n_o(timestamp_sync_n_i), .good_o(analog_high_rail_good_i));
  // stable clock from time zero
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle; a read leaves its expectation in the queue
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    if (!w)
      notes.push_back({v, m});
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= bsel;
    adr_i <= a;
    dat_i <= v;
    do
      @(posedge clk_i);
    while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // read answers against the oldest note
  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0)
    begin
      note = notes.pop_front();
      chk(dat_o & note[31:0], note[63:32]);
    end
  end
  // watchdog
  initial
  begin
    repeat (5000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
  // tests
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rail_on_i <= 1'b1;
    wb(rd, OFS_CTRL, {27'h0, CTRL_RESET}, 32'h1f);
    wb(rd, OFS_LINK_CFG, 32'h1f00, 32'h1ff1f);
    wb(rd, OFS_CAL_CFG, 32'h0, 32'h3);
    wb(rd, 8'h40, 32'h0, 32'hffffffff);
    chk({31'h0, low_voltage_rails_en_o}, 32'h1);
    rail_on_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk({31'h0, low_voltage_rails_en_o}, 32'h0);
    rail_on_i <= 1'b1;
    $display("end reset and rail");
    wb(wr, OFS_CTRL, 32'h07, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, soft_restart_o}, 32'h1);
    repeat (RESTART_QUIET_CYC) @(posedge clk_i);
    wb(rd, OFS_CTRL, 32'h06, 32'h1f);
    wb(wr, OFS_CTRL, 32'h0, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({30'h0, link_state_o}, 32'h0);
    $display("end restart");
    for (int i = 0; i < 2; i++)
    begin
      rnd = xs(rnd);
      d = {15'h0, i[0], rnd[15:8], 3'h0, rnd[4:0]};
      wb(wr, OFS_LINK_CFG, d, 32'h0);
      wb(rd, OFS_LINK_CFG, d, 32'h1ff1f);
      chk({19'h0, multiframe_len_minus_one_o, link_mode_select_o}, {19'h0, d[15:8], d[4:0]});
      use_ts_i <= i[0];
      sync_req_i <= 1'b1;
      wb(wr, OFS_CTRL, 32'h02, 32'h0);
      chk({31'h0, link_engine_enable_o}, 32'h1);
      repeat (3) @(posedge clk_i);
      chk({30'h0, link_state_o}, 32'h1);
      sync_req_i <= 1'b0;
      repeat (24) @(posedge clk_i);
      chk({30'h0, link_state_o}, 32'h3);
      wb(wr, OFS_CTRL, 32'h0, 32'h0);
    end
    $display("end link");
    bsel = 4'h2;
    wb(wr, OFS_LINK_CFG, 32'h0000_5a00, 32'h0);
    bsel = 4'hf;
    wb(rd, OFS_LINK_CFG, {d[31:16], 8'h5a, d[7:0]}, 32'h1ff1f);
    wb(wr, OFS_CAL_CFG, 32'h1, 32'h0);
    chk({30'h0, cal_background_o, cal_offset_en_o}, 32'h2);
    wb(wr, OFS_CTRL, 32'h08, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, cal_running_o}, 32'h0);
    wb(wr, OFS_CTRL, 32'h04, 32'h0);
    wb(wr, OFS_CTRL, 32'h14, 32'h0);
    chk({31'h0, overrange_detect_enable_o}, 32'h1);
    wb(wr, OFS_CTRL, 32'h16, 32'h0);
    wb(wr, OFS_CTRL, 32'h1e, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, cal_running_o}, 32'h1);
    repeat (CAL_RUN_CYC + 4) @(posedge clk_i);
    wb(rd, OFS_STATUS, 32'h10, 32'h14);
    wb(wr, OFS_CTRL, 32'h1e, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, cal_running_o}, 32'h0);
    $display("end calibration");
    complete_run();
  end
endmodule // test_css_top
